// ### inc/ptc_pkg.sv
package ptc_pkg;
    localparam int CNT_W = 48;
    localparam int SMP_W = 16;
    localparam int DAT_W = 32;
    localparam int ADR_W = 4;
    localparam int EV_W = 3;
    localparam int TB_MHZ = 100;
    localparam int CLK_MHZ = 20;
    localparam logic [47:0] TB_STEP = 48'(TB_MHZ / CLK_MHZ);
    localparam logic [47:0] CNT_MAX = 48'hFFFFFFFFFFFF;
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_ON = 4'h1;
    localparam logic [3:0] A_OFF = 4'h2;
    localparam logic [3:0] A_TMO = 4'h3;
    localparam logic [3:0] A_MIN = 4'h4;
    localparam logic [3:0] A_RNUM = 4'h5;
    localparam logic [3:0] A_RDIV = 4'h6;
    localparam logic [3:0] A_DFULL = 4'h7;
    localparam logic [3:0] A_TOL = 4'h8;
    localparam logic [3:0] A_RES = 4'h9;
    localparam logic [3:0] A_STS = 4'hA;
    localparam logic [3:0] A_MASK = 4'hB;
    localparam logic [3:0] A_PERLO = 4'hC;
    localparam logic [3:0] A_PERHI = 4'hD;
    localparam logic [3:0] A_STATE = 4'hE;
    localparam int CTRL_EN_B = 0;
    localparam int CTRL_RUN_B = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_DROP_B = 5;
    localparam int EV_RES_B = 0;
    localparam int EV_TMO_B = 1;
    localparam int EV_DROP_B = 2;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [15:0] ON_RST = 16'h0000;
    localparam logic [15:0] OFF_RST = 16'h0000;
    localparam logic [31:0] TMO_RST = 32'h00000000;
    localparam logic [31:0] MIN_RST = 32'h00000000;
    localparam logic [31:0] RNUM_RST = 32'h05F5E100;
    localparam logic [31:0] RDIV_RST = 32'h00000001;
    localparam logic [15:0] DFULL_RST = 16'h2710;
    localparam logic [7:0] TOL_RST = 8'h07;
    localparam logic [2:0] MASK_RST = 3'h0;
    typedef enum logic [2:0] {
        PTC_FREQ, PTC_PERIOD, PTC_PULSE, PTC_PAUSE, PTC_DUTY
    } ptc_mode_e;
    typedef enum logic {ST_IDLE, ST_DIV} ptc_cst_e;
endpackage : ptc_pkg

// ### verif/ptc_src.sv
`timescale 1ns/100ps
`default_nettype none
module ptc_src
(
    input wire logic clk,
    input wire logic run,
    input wire logic hold_hi,
    input wire logic [15:0] per_cyc,
    input wire logic [15:0] hi_cyc,
    input wire logic [15:0] hi_val,
    input wire logic [15:0] lo_val,
    output logic [15:0] smp
);
    logic [15:0] cnt_ff;
    initial cnt_ff = 16'h0000;
    initial smp = 16'h0000;
    // A stopped source parks at one level, like a stalled shaft
    always @(posedge clk)
    begin
        if (!run)
        begin
            cnt_ff <= 16'h0000;
            smp <= hold_hi ? hi_val : lo_val;
        end
        else
        begin
            cnt_ff <= (cnt_ff + 16'h0001 >= per_cyc) ? 16'h0000
                : cnt_ff + 16'h0001;
            smp <= (cnt_ff < hi_cyc) ? hi_val : lo_val;
        end
    end
endmodule : ptc_src
`default_nettype wire

// ### verif/pulse_timing_counter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pulse_timing_counter_tb
    import ptc_pkg::*;
;
    localparam int P = 100;
    localparam int H = 30;
    localparam int TICK = TB_MHZ / CLK_MHZ;
    logic clk, srst, ce, we, re, result_vld, led, irq;
    logic src_run, src_hold;
    logic [15:0] smp_in, per_cyc, hi_cyc, hi_val, lo_val;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, result, v;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_res = 0;
    int n_led = 0;
    logic [31:0] exp_m [5];
    logic [3:0] rst_a [8];
    logic [31:0] rst_v [8];

    ptc_top dut_u (.clk(clk), .srst(srst), .ce(ce), .smp_in(smp_in),
        .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
        .result(result), .result_vld(result_vld), .led(led), .irq(irq));
    ptc_src src_u (.clk(clk), .run(src_run), .hold_hi(src_hold),
        .per_cyc(per_cyc), .hi_cyc(hi_cyc), .hi_val(hi_val),
        .lo_val(lo_val), .smp(smp_in));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(negedge clk)
    begin
        if (result_vld === 1'b1)
            n_res++;
        if (led === 1'b1)
            n_led++;
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %h exp %h",
                $time, what, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %b", $time, what, got);
        end
    endtask : chk1

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    // Bounded wait for the n-th result pulse, then take the held result
    task automatic wait_res(input int nres, output logic [31:0] r);
        int k;
        int got;
        got = 0;
        for (k = 0; k < 3000 && got < nres; k++)
        begin
            @(negedge clk);
            if (result_vld === 1'b1)
                got++;
        end
        r = result;
        chk1(got == nres, 1'b1, "no result");
    endtask : wait_res

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        #(20000 * 50);
        n_mismatch++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        print_verdict();
    end

    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        we = 1'b0;
        re = 1'b0;
        addr = 4'h0;
        wdata = 32'h00000000;
        src_run = 1'b0;
        src_hold = 1'b0;
        per_cyc = 16'(P);
        hi_cyc = 16'(H);
        hi_val = 16'hC000;
        lo_val = 16'h1000;
        exp_m = '{32'(RNUM_RST / (P * TICK)), 32'(P * TICK), 32'(H * TICK),
            32'((P - H) * TICK), 32'(H * 32'(DFULL_RST) / P)};
        rst_a = '{A_CTRL, A_RNUM, A_RDIV, A_DFULL, A_TOL, A_MASK, A_RES, 4'hF};
        rst_v = '{32'(CTRL_RST), RNUM_RST, RDIV_RST, 32'(DFULL_RST),
            32'(TOL_RST), 32'(MASK_RST), 32'h00000000, 32'h00000000};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rd(rst_a[i], v);
            chk32(v, rst_v[i], "reset value");
        end
        wr(A_RES, 32'hFFFFFFFF);
        wr(4'hF, 32'hFFFFFFFF);
        rd(A_RES, v);
        chk32(v, 32'h00000000, "read-only written");
        rd(4'hF, v);
        chk32(v, 32'h00000000, "unmapped read");
        $display("test registers done");

        wr(A_ON, 32'h00008000);
        wr(A_OFF, 32'h00004000);
        wr(A_CTRL, 32'h00000001);
        src_run <= 1'b1;
        repeat (400) @(posedge clk);
        chk32(32'(n_res + n_led), 32'h0, "active while stopped");
        wr(A_ON, 32'h00003000);
        wr(A_CTRL, 32'h00000003);
        repeat (400) @(posedge clk);
        chk32(32'(n_res + n_led), 32'h0, "bad thresholds");
        wr(A_ON, 32'h00008000);
        lo_val <= 16'h6000;
        repeat (400) @(posedge clk);
        chk32(32'(n_res + n_led), 32'h0, "no OFF crossing");
        lo_val <= 16'h1000;
        $display("test gating done");

        for (int m = 0; m < 5; m++)
        begin
            wr(A_CTRL, 32'(m << CTRL_MODE_LSB) | 32'h3);
            // A switch may leave one stale and two partial results
            wait_res(4, v);
            chk32(v, exp_m[m], "mode");
        end
        chk1(n_led > 0, 1'b1, "indicator idle");
        rd(A_PERLO, v);
        chk32(v, 32'(P * TICK), "period low");
        rd(A_PERHI, v);
        chk32(v, 32'h00000000, "period high");
        $display("test modes done");

        wr(A_CTRL, 32'h00000027);
        wait_res(3, v);
        rd(A_STS, v);
        per_cyc <= 16'(3 * P);
        repeat (450) @(posedge clk);
        rd(A_STS, v);
        chk32(v & 32'h4, 32'h4, "drop flag");
        rd(A_RES, v);
        chk32(v, 32'(P * TICK), "drop kept");
        per_cyc <= 16'(P);
        $display("test drop done");

        wr(A_TMO, 32'd1000);
        wr(A_MIN, 32'h00001234);
        wr(A_MASK, 32'h00000002);
        wr(A_CTRL, 32'h00000003);
        wait_res(3, v);
        rd(A_STS, v);
        src_run <= 1'b0;
        wait_res(1, v);
        chk32(v, 32'h00001234, "timeout minimum");
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk1(irq, 1'b1, "irq raised");
        rd(A_STS, v);
        chk32(v & 32'h2, 32'h2, "timeout flag");
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk1(irq, 1'b0, "irq cleared");
        wr(A_CTRL, 32'h00000013);
        src_run <= 1'b1;
        wait_res(3, v);
        src_hold <= 1'b1;
        src_run <= 1'b0;
        // Parking high in the low phase adds one last valid edge first
        wait_res(2, v);
        chk32(v, 32'(DFULL_RST), "duty stuck high");
        src_run <= 1'b1;
        wait_res(3, v);
        src_hold <= 1'b0;
        src_run <= 1'b0;
        wait_res(1, v);
        chk32(v, 32'h00000000, "duty stuck low");
        $display("test timeout done");
        print_verdict();
    end
endmodule : pulse_timing_counter_tb
`default_nettype wire

// ### verilog/ptc_div.sv
`timescale 1ns/100ps
`default_nettype none
module ptc_div
    import ptc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic start,
    input wire logic [63:0] num,
    input wire logic [47:0] den,
    output logic done,
    output logic [63:0] quo
);
    logic busy_ff, nxt_busy;
    logic [6:0] step_ff, nxt_step;
    logic [48:0] rem_ff, nxt_rem;
    logic [63:0] q_ff, nxt_q;
    logic done_ff, nxt_done;
    logic [48:0] rem_sh;

    // Restoring division, one quotient bit per cycle; a zero divisor
    // yields all ones, which the caller saturates.
    always_comb
    begin
        nxt_busy = busy_ff;
        nxt_step = step_ff;
        nxt_rem = rem_ff;
        nxt_q = q_ff;
        nxt_done = 1'b0;
        rem_sh = {rem_ff[47:0], q_ff[63]};
        if (start)
        begin
            nxt_busy = 1'b1;
            nxt_step = 7'h00;
            nxt_rem = 49'h0;
            nxt_q = num;
        end
        else if (busy_ff)
        begin
            nxt_q = {q_ff[62:0], 1'b0};
            nxt_rem = rem_sh;
            if (rem_sh >= {1'b0, den})
            begin
                nxt_rem = rem_sh - {1'b0, den};
                nxt_q[0] = 1'b1;
            end
            nxt_step = step_ff + 7'h01;
            if (step_ff == 7'h3F)
            begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            busy_ff <= 1'b0;
            step_ff <= 7'h00;
            rem_ff <= 49'h0;
            q_ff <= 64'h0;
            done_ff <= 1'b0;
        end
        else if (ce)
        begin
            busy_ff <= nxt_busy;
            step_ff <= nxt_step;
            rem_ff <= nxt_rem;
            q_ff <= nxt_q;
            done_ff <= nxt_done;
        end
    end

    assign done = done_ff;
    assign quo = q_ff;
endmodule : ptc_div
`default_nettype wire

// ### verilog/ptc_top.sv
// Function
// [R1] Time the comparator output with a 48-bit counter.
// [R2] Count high phase and full period in 100 MHz timebase ticks.
// [R3] Square the input with separate ON and OFF levels (hysteresis).
// [R4] On timeout without ON crossing, output the configured minimum value.
// [R5] A measurement is valid only after alternating ON and OFF crossings.
// [R6] Frequency mode: scaled reciprocal of the period count.
// [R7] Duty mode: pulse count over period count, scaled.
// [R8] Duty at too-low frequency: 0 % if low, 100 % if high.
// [R9] Period mode: scaled count between two successive ON crossings.
// [R10] Pulse mode: scaled count from ON crossing to next OFF crossing.
// [R11] Pause mode: pulse measurement on the inverted comparator signal.
// [R12] Optional mode ignores frequency drops within a set tolerance; the code ignores drops beyond it.
// [R13] Indicator shows acquisition only when both levels are reached.
// [R14] Indicator follows signal only if enabled, running, thresholds valid.
// [R15] Software should program a timeout to bound dead-signal delay.
// [R16] Restart counters at each qualifying crossing; saturate at maximum.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module ptc_top
    import ptc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [SMP_W-1:0] smp_in,
    input wire logic [ADR_W-1:0] addr,
    input wire logic [DAT_W-1:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [DAT_W-1:0] rdata,
    output logic [DAT_W-1:0] result,
    output logic result_vld,
    output logic led,
    output logic irq
);
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction : hit

    logic [SMP_W-1:0] smp_s1_ff, smp_s2_ff;
    logic cmp_ff, nxt_cmp, eff_d_ff;
    logic [5:0] ctrl_ff, nxt_ctrl;
    logic [15:0] on_ff, nxt_on, off_ff, nxt_off, dfull_ff, nxt_dfull;
    logic [31:0] tmo_ff, nxt_tmo, min_ff, nxt_min;
    logic [31:0] rnum_ff, nxt_rnum, rdiv_ff, nxt_rdiv;
    logic [7:0] tol_ff, nxt_tol;
    logic [EV_W-1:0] sts_ff, nxt_sts, mask_ff, nxt_mask, ev;
    logic [DAT_W-1:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq, led_ff, nxt_led;
    logic thr_ok, active, eff, rise, fall, drop_hit;
    ptc_mode_e mode;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt, per_ff, nxt_per;
    logic [CNT_W-1:0] wid_ff, nxt_wid, last_ff, nxt_last;
    logic armed_ff, nxt_armed, seen_off_ff, nxt_seen_off;
    logic timed_ff, nxt_timed, locked_ff, nxt_locked;
    logic go_ff, nxt_go, tmo_go_ff, nxt_tmo_go, drop_ev_ff, nxt_drop_ev;
    ptc_cst_e cst_ff, nxt_cst;
    logic start_ff, nxt_start, vld_ff, nxt_vld, div_done;
    logic [63:0] num_ff, nxt_num, div_quo;
    logic [47:0] den_ff, nxt_den;
    logic [DAT_W-1:0] res_ff, nxt_res;

    // Multi-bit sample is assumed slow against clk; two stages only
    // guard against metastability, not against word skew.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            smp_s1_ff <= 16'h0000;
            smp_s2_ff <= 16'h0000;
        end
        else if (ce)
        begin
            smp_s1_ff <= smp_in;
            smp_s2_ff <= smp_s1_ff;
        end
    end

    assign thr_ok = (on_ff > off_ff);
    assign active = ctrl_ff[CTRL_EN_B] & ctrl_ff[CTRL_RUN_B] & thr_ok;
    assign mode = ptc_mode_e'(ctrl_ff[CTRL_MODE_LSB +: 3]);
    assign eff = cmp_ff ^ (mode == PTC_PAUSE); // [R11]
    assign rise = eff & ~eff_d_ff;
    assign fall = ~eff & eff_d_ff;
    assign drop_hit = ({6'h00, cnt_ff, 2'b00}
                       > (56'(last_ff) * 56'(tol_ff))); // [R12]

    always_comb
    begin
        nxt_cmp = cmp_ff;
        if (thr_ok && smp_s2_ff >= on_ff)
            nxt_cmp = 1'b1; // [R3]
        else if (thr_ok && smp_s2_ff <= off_ff)
            nxt_cmp = 1'b0; // [R3]
        nxt_led = active & locked_ff & ~timed_ff & cmp_ff; // [R13] [R14]
    end

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_per = per_ff;
        nxt_wid = wid_ff;
        nxt_last = last_ff;
        nxt_armed = armed_ff;
        nxt_seen_off = seen_off_ff;
        nxt_timed = timed_ff;
        nxt_locked = locked_ff;
        nxt_go = 1'b0;
        nxt_tmo_go = 1'b0;
        nxt_drop_ev = 1'b0;
        if (!active)
        begin
            nxt_cnt = '0;
            nxt_armed = 1'b0;
            nxt_seen_off = 1'b0;
            nxt_timed = 1'b0;
            nxt_locked = 1'b0;
        end
        else if (rise)
        begin
            // The crossing cycle itself belongs to the new period
            nxt_cnt = TB_STEP; // [R16]
            nxt_armed = 1'b1;
            nxt_seen_off = 1'b0;
            nxt_timed = 1'b0;
            if (armed_ff && seen_off_ff) // [R5]
            begin
                // A long gap from missing teeth keeps the last result
                if (ctrl_ff[CTRL_DROP_B] && last_ff != '0 && drop_hit)
                    nxt_drop_ev = 1'b1; // [R12]
                else
                begin
                    nxt_go = 1'b1;
                    nxt_per = cnt_ff; // [R9]
                    nxt_last = cnt_ff;
                    nxt_locked = 1'b1;
                end
            end
        end
        else
        begin
            if (cnt_ff > CNT_MAX - TB_STEP)
                nxt_cnt = CNT_MAX; // [R16]
            else
                nxt_cnt = cnt_ff + TB_STEP; // [R1] [R2]
            if (fall && armed_ff && !seen_off_ff)
            begin
                nxt_wid = cnt_ff; // [R10]
                nxt_seen_off = 1'b1;
            end
            if (tmo_ff != '0 && !timed_ff && cnt_ff >= {16'h0000, tmo_ff})
            begin
                nxt_timed = 1'b1; // [R4]
                nxt_armed = 1'b0;
                nxt_locked = 1'b0;
                nxt_tmo_go = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmp_ff <= 1'b0;
            eff_d_ff <= 1'b0;
            led_ff <= 1'b0;
            cnt_ff <= '0;
            per_ff <= '0;
            wid_ff <= '0;
            last_ff <= '0;
            armed_ff <= 1'b0;
            seen_off_ff <= 1'b0;
            timed_ff <= 1'b0;
            locked_ff <= 1'b0;
            go_ff <= 1'b0;
            tmo_go_ff <= 1'b0;
            drop_ev_ff <= 1'b0;
        end
        else if (ce)
        begin
            cmp_ff <= nxt_cmp;
            eff_d_ff <= eff;
            led_ff <= nxt_led;
            cnt_ff <= nxt_cnt;
            per_ff <= nxt_per;
            wid_ff <= nxt_wid;
            last_ff <= nxt_last;
            armed_ff <= nxt_armed;
            seen_off_ff <= nxt_seen_off;
            timed_ff <= nxt_timed;
            locked_ff <= nxt_locked;
            go_ff <= nxt_go;
            tmo_go_ff <= nxt_tmo_go;
            drop_ev_ff <= nxt_drop_ev;
        end
    end

    // A new period while dividing is dropped: the divider needs 65 cycles,
    // far below any period the 48-bit count is meant for.
    always_comb
    begin
        nxt_cst = cst_ff;
        nxt_start = 1'b0;
        nxt_num = num_ff;
        nxt_den = den_ff;
        nxt_res = res_ff;
        nxt_vld = 1'b0;
        case (cst_ff)
            ST_IDLE:
            begin
                if (go_ff)
                begin
                    nxt_start = 1'b1;
                    nxt_cst = ST_DIV;
                    case (mode)
                        PTC_PERIOD:
                        begin
                            nxt_num = 64'(per_ff); // [R9]
                            nxt_den = 48'(rdiv_ff);
                        end
                        PTC_PULSE, PTC_PAUSE:
                        begin
                            nxt_num = 64'(wid_ff); // [R10] [R11]
                            nxt_den = 48'(rdiv_ff);
                        end
                        PTC_DUTY:
                        begin
                            nxt_num = 64'(wid_ff) * 64'(dfull_ff); // [R7]
                            nxt_den = per_ff;
                        end
                        default:
                        begin
                            nxt_num = 64'(rnum_ff); // [R6]
                            nxt_den = per_ff;
                        end
                    endcase
                end
                else if (tmo_go_ff)
                begin
                    nxt_vld = 1'b1;
                    if (mode == PTC_DUTY)
                        nxt_res = cmp_ff ? 32'(dfull_ff) : 32'h0; // [R8]
                    else
                        nxt_res = min_ff; // [R4]
                end
            end
            ST_DIV:
            begin
                if (div_done)
                begin
                    nxt_vld = 1'b1;
                    nxt_cst = ST_IDLE;
                    if (div_quo[63:32] != 32'h0)
                        nxt_res = 32'hFFFFFFFF;
                    else
                        nxt_res = div_quo[31:0];
                end
            end
            default:
                nxt_cst = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cst_ff <= ST_IDLE;
            start_ff <= 1'b0;
            num_ff <= 64'h0;
            den_ff <= 48'h0;
            res_ff <= 32'h0;
            vld_ff <= 1'b0;
        end
        else if (ce)
        begin
            cst_ff <= nxt_cst;
            start_ff <= nxt_start;
            num_ff <= nxt_num;
            den_ff <= nxt_den;
            res_ff <= nxt_res;
            vld_ff <= nxt_vld;
        end
    end

    ptc_div u_div (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .start(start_ff),
        .num(num_ff),
        .den(den_ff),
        .done(div_done),
        .quo(div_quo)
    );

    assign ev = {drop_ev_ff, tmo_go_ff, vld_ff};

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_on = on_ff;
        nxt_off = off_ff;
        nxt_tmo = tmo_ff;
        nxt_min = min_ff;
        nxt_rnum = rnum_ff;
        nxt_rdiv = rdiv_ff;
        nxt_dfull = dfull_ff;
        nxt_tol = tol_ff;
        nxt_mask = mask_ff;
        nxt_rdata = 32'h0;
        if (we)
        begin
            if (hit(addr, A_CTRL)) nxt_ctrl = wdata[5:0];
            if (hit(addr, A_ON)) nxt_on = wdata[15:0];
            if (hit(addr, A_OFF)) nxt_off = wdata[15:0];
            if (hit(addr, A_TMO)) nxt_tmo = wdata;
            if (hit(addr, A_MIN)) nxt_min = wdata;
            if (hit(addr, A_RNUM)) nxt_rnum = wdata;
            if (hit(addr, A_RDIV)) nxt_rdiv = wdata;
            if (hit(addr, A_DFULL)) nxt_dfull = wdata[15:0];
            if (hit(addr, A_TOL)) nxt_tol = wdata[7:0];
            if (hit(addr, A_MASK)) nxt_mask = wdata[EV_W-1:0];
        end
        // Set beats the read-clear so a coincident event is kept
        nxt_sts = ev | (sts_ff & ~{EV_W{re & hit(addr, A_STS)}});
        nxt_irq = |(sts_ff & mask_ff);
        if (re)
        begin
            case (addr)
                A_CTRL: nxt_rdata = 32'(ctrl_ff);
                A_ON: nxt_rdata = 32'(on_ff);
                A_OFF: nxt_rdata = 32'(off_ff);
                A_TMO: nxt_rdata = tmo_ff;
                A_MIN: nxt_rdata = min_ff;
                A_RNUM: nxt_rdata = rnum_ff;
                A_RDIV: nxt_rdata = rdiv_ff;
                A_DFULL: nxt_rdata = 32'(dfull_ff);
                A_TOL: nxt_rdata = 32'(tol_ff);
                A_RES: nxt_rdata = res_ff;
                A_STS: nxt_rdata = 32'(sts_ff);
                A_MASK: nxt_rdata = 32'(mask_ff);
                A_PERLO: nxt_rdata = per_ff[31:0];
                A_PERHI: nxt_rdata = 32'(per_ff[47:32]);
                A_STATE: nxt_rdata = 32'({led_ff, cmp_ff, locked_ff,
                                         timed_ff, armed_ff});
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_ff <= CTRL_RST;
            on_ff <= ON_RST;
            off_ff <= OFF_RST;
            tmo_ff <= TMO_RST;
            min_ff <= MIN_RST;
            rnum_ff <= RNUM_RST;
            rdiv_ff <= RDIV_RST;
            dfull_ff <= DFULL_RST;
            tol_ff <= TOL_RST;
            mask_ff <= MASK_RST;
            sts_ff <= '0;
            irq_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end
        else if (ce)
        begin
            ctrl_ff <= nxt_ctrl;
            on_ff <= nxt_on;
            off_ff <= nxt_off;
            tmo_ff <= nxt_tmo;
            min_ff <= nxt_min;
            rnum_ff <= nxt_rnum;
            rdiv_ff <= nxt_rdiv;
            dfull_ff <= nxt_dfull;
            tol_ff <= nxt_tol;
            mask_ff <= nxt_mask;
            sts_ff <= nxt_sts;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;
    assign result = res_ff;
    assign result_vld = vld_ff;
    assign led = led_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_valid_rise;
        ce && active && rise && armed_ff && seen_off_ff;
    endsequence

    cmp_on_a: assert property (ce && thr_ok && smp_s2_ff >= on_ff // [R3]
        |=> cmp_ff) else $error("comparator missed ON level");
    cmp_off_a: assert property (ce && thr_ok && smp_s2_ff <= off_ff // [R3]
        && smp_s2_ff < on_ff |=> !cmp_ff)
        else $error("comparator missed OFF level");
    cnt_restart_a: assert property (ce && active && rise // [R16]
        |=> cnt_ff == TB_STEP) else $error("counter not restarted");
    cnt_sat_a: assert property (ce && active && !rise // [R16]
        && cnt_ff == CNT_MAX |=> cnt_ff == CNT_MAX)
        else $error("counter wrapped");
    alt_valid_a: assert property ($past(ce) && go_ff // [R5]
        |-> $past(seen_off_ff) && $past(armed_ff))
        else $error("result without OFF crossing");
    per_capture_a: assert property ((s_valid_rise // [R9]
        and !ctrl_ff[CTRL_DROP_B]) |=> go_ff && per_ff == $past(cnt_ff))
        else $error("period not captured");
    tmo_min_a: assert property (ce && tmo_go_ff && cst_ff == ST_IDLE // [R4]
        && !go_ff && mode != PTC_DUTY |=> vld_ff && res_ff == $past(min_ff))
        else $error("timeout minimum not output");
    duty_low_a: assert property (ce && tmo_go_ff && cst_ff == ST_IDLE // [R8]
        && !go_ff && mode == PTC_DUTY && !cmp_ff |=> res_ff == 32'h0)
        else $error("duty not 0 at low level");
    led_gate_a: assert property (ce && !active |=> !led_ff) // [R14]
        else $error("indicator lit while inactive");
    irq_level_a: assert property (ce |=> irq_ff == $past(|(sts_ff & mask_ff)))
        else $error("interrupt level wrong");
endmodule : ptc_top
`default_nettype wire
